// ===== logic/selftest_status_top.sv
// Purpose: selective self-test log fields and reliability status query
// Assumes: task-file values are stable when cmdStrobe pulses
// Notes:   all outputs come from flip-flops
//
// Functional notes
// [R1] current lba tracks block, zero when finished
// [R2] current span tracks span, six during scan
// [R3] active flag set while follow-on scan runs
// [R4] pending flag set while scan awaits start
// [R5] host scan request honoured and read back
// [R6] host writes zero to reserved flag bits
// [R7] pending scan resumes after pending minutes
// [R8] last byte makes sector sum zero
// [R9] host loads da, 4f, c2 then b0
// [R10] query sets busy, saves attributes, compares
// [R11] no crossing returns 4f and c2
// [R12] crossing returns f4 and 2c
// [R13] abort when disabled or values wrong
// [R14] then clear busy and raise interrupt
`timescale 1ns/1ps
module selftest_status_top #(
    parameter int unsigned CYCLES_PER_MIN = selftest_status_pkg::MINUTE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    // task file
    input  wire logic       cmdStrobe,        // command register written
    input  wire logic [7:0] cmdCode,          // command register
    input  wire logic [7:0] featuresIn,       // features register
    input  wire logic [7:0] lbaMidIn,         // lba mid register
    input  wire logic [7:0] lbaHighIn,        // lba high register
    input  wire logic       reliabilityOn,    // reliability feature enabled
    input  wire logic       intrqClear,       // host read of status
    output logic            busy,             // bsy
    output logic            intrq,            // interrupt request
    output logic            abortErr,         // aborted-command error
    output logic      [7:0] lbaMidOut,        // result lba mid
    output logic      [7:0] lbaHighOut,       // result lba high
    // attribute store and compare
    output logic            attrSaveReq,      // save attributes request
    input  wire logic       attrSaveAck,      // save finished
    input  wire logic       thresholdCrossed, // some attribute past threshold
    // media test engine
    input  wire logic       testStart,        // selective test launched
    input  wire logic [2:0] spanCount,        // spans configured
    input  wire logic       blockStart,       // new block under test
    input  wire logic [63:0] blockLba,        // first lba of that block
    input  wire logic       spanDone,         // span finished
    input  wire logic       scanDone,         // follow-on scan finished
    input  wire logic       scanHalt,         // scan broken off by power-down
    output logic            scanResume,       // pulse: resume the scan
    // log sector access
    input  wire logic       logWrStrobe,      // host writes one byte
    input  wire logic [8:0] logWrIndex,       // byte position
    input  wire logic [7:0] logWrData,        // byte written
    input  wire logic [8:0] logRdIndex,       // byte to read
    output logic      [7:0] logRdData,        // byte read, one cycle later
    output logic            checksumReady     // checksum matches contents
);
    // status query sequence
    typedef enum {Q_IDLE, Q_ABORT, Q_SAVE, Q_COMPARE} query_e;
    // selective test progress
    typedef enum {T_IDLE, T_SPAN, T_SCAN} test_e;

    // all state of this block
    typedef struct packed {
        query_e                             q;          // query state
        test_e                              t;          // test state
        logic                               busy;       // bsy
        logic                               intrq;      // interrupt
        logic                               abortErr;   // aborted command
        logic [7:0]                         lbaMid;     // result mid
        logic [7:0]                         lbaHigh;    // result high
        logic                               attrSave;   // save request
        logic [selftest_status_pkg::HOST_BYTES-1:0][7:0] hostBytes; // host area
        logic [63:0]                        curLba;     // block under test
        logic [15:0]                        curSpan;    // span under test
        logic [15:0]                        flags;      // feature flags
        logic [23:0]                        pendMin;    // pending minutes
        logic [23:0]                        elapsedMin; // minutes since power-on
        logic                               scanResume; // resume pulse
        logic [7:0]                         rdData;     // read data
        logic                               chkReady;   // checksum current
    } state_s;

    state_s     st;
    state_s     next_st;
    logic       minuteTick;  // one pulse per minute
    logic [8:0] chkIndex;    // checksum walk position
    logic [7:0] chkValue;    // checksum result
    logic       chkValid;    // checksum current
    logic [7:0] chkByte;     // byte fed to the checksum
    logic       dirty;       // sector contents change

    // byte of the log sector image at a position, checksum byte excluded
    function automatic logic [7:0] log_byte(input state_s s, input logic [8:0] idx);
        logic [8:0] rel;
        log_byte = 8'h00;
        rel      = 9'h000;
        if (idx < selftest_status_pkg::OFS_HOST_END)
            log_byte = s.hostBytes[idx];
        else if (idx < selftest_status_pkg::OFS_CUR_SPAN)
        begin
            rel      = idx - selftest_status_pkg::OFS_CUR_LBA;
            log_byte = s.curLba[rel[2:0]*8 +: 8];
        end
        else if (idx < selftest_status_pkg::OFS_FLAGS)
            log_byte = idx[0] ? s.curSpan[15:8] : s.curSpan[7:0];
        else if (idx == selftest_status_pkg::OFS_FLAGS)
            log_byte = s.flags[7:0];
        else if (idx == selftest_status_pkg::OFS_FLAGS + 9'h001)
            log_byte = s.flags[15:8];
        else if (idx >= selftest_status_pkg::OFS_PEND_TIME
                 && idx < selftest_status_pkg::OFS_CHECKSUM)
        begin
            rel      = idx - selftest_status_pkg::OFS_PEND_TIME;
            log_byte = s.pendMin[rel[1:0]*8 +: 8];
        end
    endfunction : log_byte

    // minute base for the pending time
    minute_ticker #(
        .CYCLES (CYCLES_PER_MIN)
    ) u_minute (
        .clk    (clk),
        .arst_n (arst_n),
        .tick   (minuteTick)
    );

    // checksum over the live sector image
    sector_checksum u_checksum (
        .clk       (clk),
        .arst_n    (arst_n),
        .scanByte  (chkByte),
        .dirty     (dirty),
        .scanIndex (chkIndex),
        .checksum  (chkValue),
        .valid     (chkValid)
    );

    assign chkByte = log_byte(st, chkIndex);

    // next-state logic for query, test progress and log access
    always_comb
    begin
        logic [8:0] rel;
        rel                = 9'h000;
        next_st            = st;
        next_st.scanResume = 1'b0;

        // status query; host clear first so a new set wins
        if (intrqClear)
            next_st.intrq = 1'b0;
        case (st.q)
            Q_IDLE:
            begin
                if (cmdStrobe && cmdCode == selftest_status_pkg::CMD_RELIABILITY) // R9
                begin
                    next_st.busy     = 1'b1; // R10
                    next_st.abortErr = 1'b0;
                    if (!reliabilityOn
                        || featuresIn != selftest_status_pkg::FEAT_STATUS
                        || lbaMidIn != selftest_status_pkg::SIG_MID_OK
                        || lbaHighIn != selftest_status_pkg::SIG_HIGH_OK)
                        next_st.q = Q_ABORT; // R13
                    else
                    begin
                        next_st.attrSave = 1'b1; // R10
                        next_st.q        = Q_SAVE;
                    end
                end
            end
            Q_ABORT:
            begin
                // post the error and finish
                next_st.abortErr = 1'b1; // R13
                next_st.busy     = 1'b0;
                next_st.intrq    = 1'b1;
                next_st.q        = Q_IDLE;
            end
            Q_SAVE:
            begin
                // hold the save request until the store answers
                if (attrSaveAck)
                begin
                    next_st.attrSave = 1'b0;
                    next_st.q        = Q_COMPARE; // R10
                end
            end
            Q_COMPARE:
            begin
                if (thresholdCrossed)
                begin
                    next_st.lbaMid  = selftest_status_pkg::SIG_MID_FAIL;  // R12
                    next_st.lbaHigh = selftest_status_pkg::SIG_HIGH_FAIL; // R12
                end
                else
                begin
                    next_st.lbaMid  = selftest_status_pkg::SIG_MID_OK;    // R11
                    next_st.lbaHigh = selftest_status_pkg::SIG_HIGH_OK;   // R11
                end
                next_st.busy  = 1'b0; // R14
                next_st.intrq = 1'b1; // R14
                next_st.q     = Q_IDLE;
            end
            default:
                next_st.q = Q_IDLE;
        endcase

        // host writes to the log sector
        if (logWrStrobe)
        begin
            if (logWrIndex < selftest_status_pkg::OFS_HOST_END)
                next_st.hostBytes[logWrIndex] = logWrData;
            else if (logWrIndex < selftest_status_pkg::OFS_CUR_SPAN)
            begin
                rel = logWrIndex - selftest_status_pkg::OFS_CUR_LBA;
                next_st.curLba[rel[2:0]*8 +: 8] = logWrData; // R1
            end
            else if (logWrIndex < selftest_status_pkg::OFS_FLAGS)
            begin
                if (logWrIndex[0])
                    next_st.curSpan[15:8] = logWrData;
                else
                    next_st.curSpan[7:0] = logWrData;
            end
            else if (logWrIndex == selftest_status_pkg::OFS_FLAGS)
                // only the scan request is taken; the device owns 3 and 4
                next_st.flags[selftest_status_pkg::FLAG_SCAN_REQ] =
                    logWrData[selftest_status_pkg::FLAG_SCAN_REQ]; // R5 R6
            else if (logWrIndex >= selftest_status_pkg::OFS_PEND_TIME
                     && logWrIndex < selftest_status_pkg::OFS_CHECKSUM)
            begin
                rel = logWrIndex - selftest_status_pkg::OFS_PEND_TIME;
                next_st.pendMin[rel[1:0]*8 +: 8] = logWrData;
            end
        end

        // minutes since power-on, held at the top
        if (minuteTick && st.elapsedMin != 24'hffffff)
            next_st.elapsedMin = st.elapsedMin + 24'h000001;

        // selective test progress; device updates win over host writes
        case (st.t)
            T_IDLE:
            begin
                if (testStart)
                begin
                    next_st.t       = T_SPAN;
                    next_st.curSpan = selftest_status_pkg::SPAN_FIRST; // R2
                end
                else if (st.flags[selftest_status_pkg::FLAG_PENDING]
                         && st.elapsedMin >= st.pendMin)
                begin
                    next_st.flags[selftest_status_pkg::FLAG_PENDING] = 1'b0; // R7
                    next_st.flags[selftest_status_pkg::FLAG_ACTIVE]  = 1'b1; // R7
                    next_st.curSpan    = selftest_status_pkg::SPAN_SCAN;
                    next_st.scanResume = 1'b1; // R7
                    next_st.t          = T_SCAN;
                end
            end
            T_SPAN:
            begin
                if (blockStart)
                    next_st.curLba = blockLba; // R1
                if (spanDone)
                begin
                    if (st.curSpan < {13'h0000, spanCount})
                        next_st.curSpan = st.curSpan + 16'h0001; // R2
                    else if (st.flags[selftest_status_pkg::FLAG_SCAN_REQ]) // R5
                    begin
                        next_st.flags[selftest_status_pkg::FLAG_PENDING] = 1'b1; // R4
                        next_st.t = T_SCAN;
                    end
                    else
                    begin
                        next_st.curLba  = 64'h0;                    // R1
                        next_st.curSpan = selftest_status_pkg::SPAN_NONE; // R2
                        next_st.t       = T_IDLE;
                    end
                end
            end
            T_SCAN:
            begin
                // pending lasts one cycle here, then the scan is active
                if (st.flags[selftest_status_pkg::FLAG_PENDING])
                begin
                    next_st.flags[selftest_status_pkg::FLAG_PENDING] = 1'b0; // R4
                    next_st.flags[selftest_status_pkg::FLAG_ACTIVE]  = 1'b1; // R3
                    next_st.curSpan = selftest_status_pkg::SPAN_SCAN;        // R2
                end
                else if (blockStart)
                    next_st.curLba = blockLba; // R1
                if (scanHalt)
                begin
                    // power going down: park the scan as pending
                    next_st.flags[selftest_status_pkg::FLAG_ACTIVE]  = 1'b0; // R3
                    next_st.flags[selftest_status_pkg::FLAG_PENDING] = 1'b1; // R4
                    next_st.t = T_IDLE;
                end
                else if (scanDone)
                begin
                    next_st.flags[selftest_status_pkg::FLAG_ACTIVE] = 1'b0; // R3
                    next_st.curLba  = 64'h0;                                // R1
                    next_st.curSpan = selftest_status_pkg::SPAN_NONE;       // R2
                    next_st.t       = T_IDLE;
                end
            end
            default:
                next_st.t = T_IDLE;
        endcase

        // registered read port, checksum in the last byte
        if (logRdIndex == selftest_status_pkg::OFS_CHECKSUM)
            next_st.rdData = chkValue; // R8
        else
            next_st.rdData = log_byte(st, logRdIndex);
        next_st.chkReady = chkValid && !dirty;
    end

    // any change of the summed bytes spoils the checksum pass in progress, which is then rerun
    assign dirty = (next_st.hostBytes != st.hostBytes) || (next_st.curLba != st.curLba)
                || (next_st.curSpan != st.curSpan) || (next_st.flags != st.flags)
                || (next_st.pendMin != st.pendMin);

    // state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st   <= '0;
            st.q <= Q_IDLE;
            st.t <= T_IDLE;
        end
        else
            st <= next_st;
    end

    assign busy          = st.busy;
    assign intrq         = st.intrq;
    assign abortErr      = st.abortErr;
    assign lbaMidOut     = st.lbaMid;
    assign lbaHighOut    = st.lbaHigh;
    assign attrSaveReq   = st.attrSave;
    assign scanResume    = st.scanResume;
    assign logRdData     = st.rdData;
    assign checksumReady = st.chkReady;
endmodule : selftest_status_top

// ===== logic/selftest_status_pkg.sv
// Purpose: shared constants for the self-test log sector and status query logic
// Assumes: 10 MHz clock, byte-wide log sector access
// Notes:   byte offsets are positions within the 512-byte log sector
package selftest_status_pkg;

    // clock and time base
    localparam int unsigned CLK_HZ          = 10_000_000;  // clock rate in hertz
    localparam int unsigned MINUTE_S        = 60;          // one minute in seconds
    localparam int unsigned MINUTE_CYCLES   = MINUTE_S * CLK_HZ; // cycles per minute

    // task-file values of the status query
    localparam logic [7:0] CMD_RELIABILITY  = 8'hb0;       // command code
    localparam logic [7:0] FEAT_STATUS      = 8'hda;       // features sub-code
    localparam logic [7:0] SIG_MID_OK       = 8'h4f;       // mid, no threshold crossed
    localparam logic [7:0] SIG_HIGH_OK      = 8'hc2;       // high, no threshold crossed
    localparam logic [7:0] SIG_MID_FAIL     = 8'hf4;       // mid, threshold crossed
    localparam logic [7:0] SIG_HIGH_FAIL    = 8'h2c;       // high, threshold crossed

    // log sector layout
    localparam logic [8:0] OFS_HOST_END     = 9'h1ec;      // first byte past host area (492)
    localparam logic [8:0] OFS_CUR_LBA      = 9'h1ec;      // current block lba, 8 bytes
    localparam logic [8:0] OFS_CUR_SPAN     = 9'h1f4;      // current span, 2 bytes (500)
    localparam logic [8:0] OFS_FLAGS        = 9'h1f6;      // feature flags, 2 bytes (502)
    localparam logic [8:0] OFS_PEND_TIME    = 9'h1fc;      // pending minutes, 3 bytes (508)
    localparam logic [8:0] OFS_CHECKSUM     = 9'h1ff;      // checksum byte (511)
    localparam logic [8:0] OFS_SUM_LAST     = 9'h1fe;      // last byte summed (510)
    localparam int unsigned HOST_BYTES      = 492;         // bytes held for the host

    // feature flag bits
    localparam int unsigned FLAG_SCAN_REQ   = 1;           // host asks for scan after test
    localparam int unsigned FLAG_PENDING    = 3;           // scan pending
    localparam int unsigned FLAG_ACTIVE     = 4;           // scan active

    // span numbering
    localparam logic [15:0] SPAN_FIRST      = 16'h0001;    // first test span
    localparam logic [15:0] SPAN_SCAN       = 16'h0006;    // span code shown during scan
    localparam logic [15:0] SPAN_NONE       = 16'h0000;    // idle or finished

endpackage : selftest_status_pkg

// ===== logic/minute_ticker.sv
// Purpose: one-cycle tick once per minute of running time
// Assumes: count supplied by the parent, never below one
// Notes:   starts counting at reset release, which stands for power-on
`timescale 1ns/1ps
module minute_ticker #(
    parameter int unsigned CYCLES = selftest_status_pkg::MINUTE_CYCLES
) (
    input  wire logic clk,
    input  wire logic arst_n,
    output logic      tick
);
    // cycle counter plus registered tick
    typedef struct packed {
        logic [31:0] count;  // cycles elapsed in this minute
        logic        tick;   // minute boundary pulse
    } ticker_s;

    ticker_s st;
    ticker_s next_st;

    // wrap the counter at the end of each minute
    always_comb
    begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (st.count == CYCLES - 32'h1)
        begin
            next_st.count = 32'h0;
            next_st.tick  = 1'b1;
        end
        else
        begin
            next_st.count = st.count + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign tick = st.tick;
endmodule : minute_ticker

// ===== logic/sector_checksum.sv
// Purpose: background checksum over the first 511 log bytes
// Assumes: parent supplies the byte at scanIndex in the same cycle
// Notes:   a pass that saw any change is thrown away and rerun
`timescale 1ns/1ps
module sector_checksum (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [7:0] scanByte,   // byte at scanIndex
    input  wire logic       dirty,      // some byte changes this cycle
    output logic      [8:0] scanIndex,  // byte being summed
    output logic      [7:0] checksum,   // two's complement of the sum
    output logic            valid       // checksum matches present contents
);
    typedef struct packed {
        logic [8:0] idx;    // walk position
        logic [7:0] sum;    // running sum
        logic       stale;  // change seen during this pass
        logic [7:0] chk;    // last good result
        logic       valid;  // result current
    } chk_s;

    chk_s st;
    chk_s next_st;

    // walk 0..510, negate the total at the end of a clean pass
    always_comb
    begin
        next_st = st;
        if (dirty)
        begin
            next_st.stale = 1'b1;
            next_st.valid = 1'b0;
        end
        if (st.idx == selftest_status_pkg::OFS_SUM_LAST)
        begin
            if (!st.stale && !dirty)
            begin
                next_st.chk   = 8'h00 - (st.sum + scanByte); // R8
                next_st.valid = 1'b1;
            end
            next_st.idx   = 9'h000;
            next_st.sum   = 8'h00;
            next_st.stale = dirty;
        end
        else
        begin
            next_st.idx = st.idx + 9'h001;
            next_st.sum = st.sum + scanByte;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign scanIndex = st.idx;
    assign checksum  = st.chk;
    assign valid     = st.valid;
endmodule : sector_checksum

// ===== tb/selftest_status_checker.sv
// Purpose: assertions on the status query handshake of the self-test block
// Assumes: bound to selftest_status_top, one clock domain
// Notes:   log sector fields are judged by the testbench
`timescale 1ns/1ps
module selftest_status_checker (
    input wire logic       clk, arst_n, cmdStrobe, reliabilityOn, intrqClear,
    input wire logic       busy, intrq, abortErr, attrSaveReq, attrSaveAck, thresholdCrossed,
    input wire logic [7:0] cmdCode, featuresIn, lbaMidIn, lbaHighIn, lbaMidOut, lbaHighOut
);
    // query taken: b0 strobe while idle
    wire logic take = cmdStrobe && !busy && cmdCode == selftest_status_pkg::CMD_RELIABILITY;
    // feature on and task file holds the required values
    wire logic good = reliabilityOn && featuresIn == selftest_status_pkg::FEAT_STATUS
        && lbaMidIn == selftest_status_pkg::SIG_MID_OK
        && lbaHighIn == selftest_status_pkg::SIG_HIGH_OK;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_good; take && good; endsequence
    sequence s_bad; take && !good; endsequence
    sequence s_saved; attrSaveReq && attrSaveAck; endsequence
    a_query_busy: assert property (s_good |=> busy && attrSaveReq)
        else $error("query did not raise busy and save request");
    a_abort_ends: assert property (s_bad |=> busy ##1 (!busy && intrq && abortErr))
        else $error("bad query did not abort");
    a_bad_nosave: assert property (s_bad |=> !attrSaveReq [*2])
        else $error("bad query asked for a save");
    a_save_done: assert property (s_saved |=> !attrSaveReq ##1 (!busy && intrq && !abortErr))
        else $error("query did not finish after save");
    a_result_ok: assert property (s_saved ##1 !thresholdCrossed |=>
        lbaMidOut == selftest_status_pkg::SIG_MID_OK
        && lbaHighOut == selftest_status_pkg::SIG_HIGH_OK)
        else $error("good status result wrong");
    a_result_fail: assert property (s_saved ##1 thresholdCrossed |=>
        lbaMidOut == selftest_status_pkg::SIG_MID_FAIL
        && lbaHighOut == selftest_status_pkg::SIG_HIGH_FAIL)
        else $error("failing status result wrong");
    a_intrq_hold: assert property (intrq && !intrqClear |=> intrq)
        else $error("interrupt dropped before clear");
    a_other_code: assert property (cmdStrobe && !busy && !take |=> !busy [*2])
        else $error("foreign command code acted");
endmodule : selftest_status_checker
bind selftest_status_top selftest_status_checker selftest_status_checker_i (.clk, .arst_n,
    .cmdStrobe, .reliabilityOn, .intrqClear, .busy, .intrq, .abortErr, .attrSaveReq, .attrSaveAck,
    .thresholdCrossed, .cmdCode, .featuresIn, .lbaMidIn, .lbaHighIn, .lbaMidOut, .lbaHighOut);

// ===== tb/host_model.sv
// Purpose: host side of the task file, issues one command per call
// Assumes: called 10 ns after a rising edge
// Notes:   fields are zero before the first command and show inverted values after each command
`timescale 1ns/1ps
module host_model (
    input  wire logic clk,
    output logic       cmdStrobe,
    output logic [7:0] cmdCode, featuresIn, lbaMidIn, lbaHighIn
);
    initial {cmdStrobe, cmdCode, featuresIn, lbaMidIn, lbaHighIn} = '0;
    // load the fields with the command code, strobe for one edge
    task issue(input logic [7:0] c, f, m, h);
        {cmdCode, featuresIn, lbaMidIn, lbaHighIn} = {c, f, m, h};
        cmdStrobe = 1'b1;
        @(posedge clk);
        #10;
        cmdStrobe = 1'b0;
        {cmdCode, featuresIn, lbaMidIn, lbaHighIn} = ~{c, f, m, h};
    endtask : issue
endmodule : host_model

// ===== tb/selftest_status_test.sv
// Purpose: self-checking bench for the self-test log and status query
// Assumes: one minute shortened to 10 cycles
// Notes:   save acknowledge is held high
`timescale 1ns/1ps
module selftest_status_test;
    logic clk = 0, arst_n = 0, reliabilityOn = 1, intrqClear = 0, thresholdCrossed = 0;
    logic testStart = 0, blockStart = 0, spanDone = 0, scanDone = 0, scanHalt = 0;
    logic logWrStrobe = 0, attrSaveAck = 1, ea;
    logic [2:0]  spanCount = 3'h1;
    logic [63:0] blockLba = 64'h0000_0000_0003_0000;
    logic [8:0]  logWrIndex = 9'h000, logRdIndex = 9'h000;
    logic [7:0]  logWrData = 8'h00, cmdCode, featuresIn, lbaMidIn, lbaHighIn, f, m, h, em, eh, d;
    logic        cmdStrobe, busy, intrq, abortErr, attrSaveReq, scanResume, checksumReady;
    logic [7:0]  lbaMidOut, lbaHighOut, logRdData, s = 8'h00;
    int n_fail = 0, n_checks = 0, cyc = 0, k;
    // rows: enable, features, mid, high, crossed, abort, result mid, result high
    localparam logic [42:0] ROWS [7] = '{{1'b1, 24'hda4fc2, 1'b0, 1'b0, 16'h4fc2},
        {1'b1, 24'hda4fc2, 2'b10, 16'hf42c}, {1'b0, 24'hda4fc2, 2'b01, 16'hf42c},
        {1'b1, 24'hd34fc2, 2'b01, 16'hf42c}, {1'b1, 24'hda4ec2, 2'b01, 16'hf42c},
        {1'b1, 24'hda4fc3, 2'b01, 16'hf42c}, {1'b1, 24'hda4fc2, 2'b00, 16'h4fc2}};
    selftest_status_top #(.CYCLES_PER_MIN(10)) selftest_status_top_i (.clk, .arst_n, .cmdStrobe,
        .cmdCode, .featuresIn, .lbaMidIn, .lbaHighIn, .reliabilityOn, .intrqClear, .busy, .intrq,
        .abortErr, .lbaMidOut, .lbaHighOut, .attrSaveReq, .attrSaveAck, .thresholdCrossed,
        .testStart, .spanCount, .blockStart, .blockLba, .spanDone, .scanDone, .scanHalt,
        .scanResume, .logWrStrobe, .logWrIndex, .logWrData, .logRdIndex, .logRdData,
        .checksumReady);
    host_model host_model_i (.clk, .cmdStrobe, .cmdCode, .featuresIn, .lbaMidIn, .lbaHighIn);
    always #50 clk = ~clk;
    // cycles since reset release
    always @(posedge clk) if (arst_n) cyc <= cyc + 1;
    task tick(input int n); repeat (n) @(posedge clk); #10; endtask : tick
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task wr(input logic [8:0] i, input logic [7:0] v);
        {logWrIndex, logWrData, logWrStrobe} = {i, v, 1'b1};
        tick(1);
    endtask : wr
    task rd(input logic [8:0] i); logRdIndex = i; tick(1); d = logRdData; endtask : rd
    task automatic pulse(ref logic p); p = 1; tick(1); p = 0; endtask : pulse
    task summarize;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    initial begin #(6000 * 100); n_fail++; summarize(); end
    initial
    begin
        tick(8);
        chk("reset", {busy, intrq, abortErr, lbaMidOut, lbaHighOut}, 0);
        arst_n = 1;
        foreach (ROWS[i])
        begin
            {reliabilityOn, f, m, h, thresholdCrossed, ea, em, eh} = ROWS[i];
            host_model_i.issue(8'hb0, f, m, h);
            chk("busy", busy, 1);
            for (k = 0; k < 20 && intrq !== 1'b1; k++) tick(1);
            chk("done", {busy, abortErr}, {1'b0, ea});
            chk("result", {lbaMidOut, lbaHighOut}, {em, eh});
            pulse(intrqClear);
            chk("intrq", intrq, 0);
        end
        host_model_i.issue(8'he5, 8'hda, 8'h4f, 8'hc2);
        tick(3);
        chk("other", {busy, intrq}, 0);
        for (k = 0; k < 492; k++) wr(k[8:0], k == 0 ? 8'h01 : 8'h00);
        wr(9'h1f6, 8'hff);
        wr(9'h1fc, 8'h64);
        logWrStrobe = 0;
        rd(9'h1f6); chk("flags", d, 8'h02);
        pulse(testStart);
        pulse(blockStart);
        rd(9'h1ee); chk("lba", d, 8'h03);
        rd(9'h1f4); chk("span", d, 8'h01);
        pulse(spanDone);
        tick(3);
        rd(9'h1f6); chk("active", d, 8'h12);
        rd(9'h1f4); chk("scanspan", d, 8'h06);
        pulse(scanHalt);
        rd(9'h1f6); chk("pending", d, 8'h0a);
        for (k = 0; k < 1000 && scanResume !== 1'b1; k++) tick(1);
        chk("resume", cyc >= 1000 && cyc <= 1015, 1);
        rd(9'h1f6); chk("resumed", d, 8'h12);
        pulse(scanDone);
        rd(9'h1ee); chk("lbaclr", d, 0);
        rd(9'h1f4); chk("spanclr", d, 0);
        for (k = 0; k < 2000 && checksumReady !== 1'b1; k++) tick(1);
        for (k = 0; k < 512; k++) begin rd(k[8:0]); s += d; end
        chk("sum", {checksumReady, s}, {1'b1, 8'h00});
        summarize();
    end
endmodule : selftest_status_test
